// [inc/pic_defs.svh]
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// Register indices (printed offsets, not all multiples of four)
`define PIC_IDX_EN_A        8'ha8
`define PIC_IDX_EN_B        8'hb1
`define PIC_IDX_PMSB_A      8'hb7
`define PIC_IDX_PLSB_A      8'hb8
`define PIC_IDX_PMSB_B      8'hb3
`define PIC_IDX_PLSB_B      8'hb2
`define PIC_IDX_TCTRL       8'h88
`define PIC_IDX_PEND        8'hc0
`define PIC_IDX_CORE        8'hc1
`define PIC_IDX_STAT        8'hc2

// Field positions
`define PIC_GATE_BIT        7
`define PIC_EN_B_MASK       8'h5f
`define PIC_EN_A_MASK       8'h7f
`define PIC_TC_TRIG0        0
`define PIC_TC_FLAG0        1
`define PIC_TC_TRIG1        2
`define PIC_TC_FLAG1        3

// Source polling numbers
`define PIC_SRC_PIN0        0
`define PIC_SRC_TMR0        1
`define PIC_SRC_PIN1        2
`define PIC_SRC_TMR1        3

// Vector layout
`define PIC_VEC_BASE        16'h0003
`define PIC_VEC_SHIFT       3

// Sampling
`define PIC_SAMPLE_PERIOD   6
`define PIC_RESET_BYTE      8'h00

`endif

// [inc/pic_pkg.sv]
package pic_pkg;
    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } pic_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pic_apb_rsp_type;

    typedef struct packed {
        logic        irq_req;
        logic [15:0] vector;
        logic [3:0]  src_num;
        logic [1:0]  level;
    } pic_core_req_type;

    typedef struct packed {
        logic        ack;
        logic        return_from_service;
    } pic_core_rsp_type;
endpackage

// [src/pic_arbiter.sv]
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_arbiter #(
    parameter int NSRC = 15
) (
    // Requests and levels
    input  wire logic [NSRC-1:0]   req,
    input  wire logic [2*NSRC-1:0] lvl,
    // Winner
    output logic                   found,
    output logic [3:0]             win,
    output logic [1:0]             win_lvl
);
    import pic_pkg::*;

    initial begin
        if (NSRC < 1 || NSRC > 16) $error("pic_arbiter: bad NSRC");
    end

    always_comb begin
        found   = 1'b0;
        win     = 4'h0;
        win_lvl = 2'b00;
        // Descending index, greater or equal: lower number wins ties
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && (!found || lvl[2*i +: 2] >= win_lvl)) begin // RULE_03 RULE_04
                found   = 1'b1;
                win     = 4'(i);
                win_lvl = lvl[2*i +: 2];
            end
        end
    end
endmodule

// [src/pic_sampler.sv]
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_sampler #(
    parameter int WIDTH  = 3,
    parameter int PERIOD = `PIC_SAMPLE_PERIOD
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Pins and sampled levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sampled,
    output logic                  tick
);
    import pic_pkg::*;

    initial begin
        if (PERIOD < 2 || PERIOD > 255) $error("pic_sampler: bad PERIOD");
    end

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] smp;
        logic [7:0]       cnt;
        logic             tick;
    } pic_smp_st_type;

    pic_smp_st_type st_r;
    pic_smp_st_type st_nxt;

    localparam logic [7:0] LAST = 8'(PERIOD - 1);

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin_in;
        st_nxt.s2   = st_r.s1;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == LAST) begin
            st_nxt.cnt  = 8'h00;
            st_nxt.smp  = st_r.s2;   // RULE_11
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{s1: '1, s2: '1, smp: '1, cnt: 8'h00, tick: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sampled = st_r.smp;
    assign tick    = st_r.tick;

    sample_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick [*5] ##1 tick) else $error("sample tick spacing wrong"); // RULE_11
endmodule

// [src/pic_top.sv]
`timescale 1ns/1ps
`include "pic_defs.svh"

// Operation
// RULE_01 - Two-bit level per source, msb/lsb
// RULE_02 - Preempt only by strictly higher level
// RULE_03 - Highest programmed level vectored first
// RULE_04 - Ties broken by fixed polling order
// RULE_05 - Vector is 0003h plus eight times number
// RULE_06 - Clear timer and edge pin flags on vectoring
// RULE_07 - Trigger select: 0 low level, 1 falling edge
// RULE_08 - Pin event sets flag regardless of enable
// RULE_09 - Level routine clears flag, pin releases
// RULE_10 - Low request pin level wakes power-down
// RULE_11 - Pins sampled every six clock periods
// RULE_12 - Level request held over six periods
// RULE_13 - Edge request low six periods after
// RULE_14 - Global gate bit 7 blocks everything
// RULE_15 - First enable register bit layout
// RULE_16 - Second enable register bit layout
// RULE_17 - Reserved enable bits read zero
// RULE_18 - Priority bits mirror enable positions
// RULE_19 - Core finishes instruction before vectoring
// RULE_20 - Return clears in-service of top level
// RULE_21 - Request only above highest in-service level
// RULE_22 - Disabled request stays pending in flag
module pic_top (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire pic_pkg::pic_apb_req_type apb_req,
    output pic_pkg::pic_apb_rsp_type      apb_rsp,
    // External pins
    input  wire logic                   outside_request_pin_zero_n,
    input  wire logic                   outside_request_pin_one_n,
    input  wire logic                   keypad_wake_input,
    // Peripheral request flags (timers pulse, others level)
    input  wire logic                   timer_zero_event,
    input  wire logic                   timer_one_event,
    input  wire logic [10:0]            periph_flags,
    // Core handshake
    input  wire pic_pkg::pic_core_rsp_type core_rsp,
    output pic_pkg::pic_core_req_type     core_req,
    // Power-down wake
    output logic                        wake_request
);
    import pic_pkg::*;

    localparam int NSRC = 15;

    typedef struct packed {
        logic [7:0]  en_a;
        logic [7:0]  en_b;
        logic [7:0]  pmsb_a;
        logic [7:0]  plsb_a;
        logic [7:0]  pmsb_b;
        logic [7:0]  plsb_b;
        logic [1:0]  trig;
        logic [1:0]  ext_flag;
        logic [1:0]  tmr_flag;
        logic [1:0]  prev_pin;
        logic [3:0]  in_svc;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        wake;
    } pic_st_type;

    pic_st_type st_r;
    pic_st_type st_nxt;

    // Edge memory starts at the idle-high pin level
    localparam pic_st_type ST_RESET = '{prev_pin: '1, default: '0};

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    logic [2:0] smp;
    logic       tick;

    pic_sampler #(
        .WIDTH  (3),
        .PERIOD (`PIC_SAMPLE_PERIOD)
    ) u_sampler (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({keypad_wake_input, outside_request_pin_one_n,
                   outside_request_pin_zero_n}),
        .sampled (smp),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // Source vectors in polling order
    // ----------------------------------------------------------------
    logic [NSRC-1:0]   pend;
    logic [NSRC-1:0]   enab;
    logic [NSRC-1:0]   req;
    logic [2*NSRC-1:0] lvl;
    logic [NSRC-1:0]   pmsb;
    logic [NSRC-1:0]   plsb;
    logic [NSRC-1:0]   emap;
    logic [1:0]        pin_lvl;

    assign pin_lvl = ~smp[1:0];

    // Level mode: flag follows the pin while low
    always_comb begin
        pend = {1'b0, periph_flags[10], 1'b0, periph_flags[9:0], 2'b00};
        pend[`PIC_SRC_PIN0] = st_r.ext_flag[0];
        pend[`PIC_SRC_TMR0] = st_r.tmr_flag[0];
        pend[`PIC_SRC_PIN1] = st_r.ext_flag[1];
        pend[`PIC_SRC_TMR1] = st_r.tmr_flag[1];
        pend[4]  = periph_flags[0];
        pend[5]  = periph_flags[1];
        pend[6]  = periph_flags[2];
        pend[7]  = periph_flags[3];
        pend[8]  = periph_flags[4];
        pend[9]  = periph_flags[5];
        pend[10] = periph_flags[6];
        pend[11] = periph_flags[7] | periph_flags[8]; // keypad flag or its input logic
        pend[13] = periph_flags[9];
        pend[14] = 1'b0;
        pend[12] = 1'b0;
    end

    // Map enable/priority bit positions onto polling numbers
    function automatic logic [NSRC-1:0] to_poll(input logic [7:0] a, input logic [7:0] b);
        to_poll = {1'b0, b[6], 1'b0, b[4], b[3], b[2], b[1], b[0],
                   a[6], a[5], a[4], a[3], a[1 + 1], a[1], a[0]};
    endfunction

    assign emap = to_poll(st_r.en_a, st_r.en_b);                      // RULE_15 RULE_16
    assign pmsb = to_poll(st_r.pmsb_a, st_r.pmsb_b);                  // RULE_18
    assign plsb = to_poll(st_r.plsb_a, st_r.plsb_b);                  // RULE_18
    assign enab = st_r.en_a[`PIC_GATE_BIT] ? emap : '0;               // RULE_14
    assign req  = pend & enab;                                        // RULE_22

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_lvl
            assign lvl[2*g +: 2] = {pmsb[g], plsb[g]};                // RULE_01
        end
    endgenerate

    logic       found;
    logic [3:0] win;
    logic [1:0] win_lvl;

    pic_arbiter #(
        .NSRC (NSRC)
    ) u_arb (
        .req     (req),
        .lvl     (lvl),
        .found   (found),
        .win     (win),
        .win_lvl (win_lvl)
    );

    // Highest level in service, 0 when idle (svc_any low)
    logic       svc_any;
    logic [1:0] svc_top;
    always_comb begin
        svc_any = |st_r.in_svc;
        svc_top = 2'b00;
        for (int i = 0; i < 4; i++) begin
            if (st_r.in_svc[i]) svc_top = 2'(i);
        end
    end

    logic take;
    assign take = found && (!svc_any || win_lvl > svc_top);            // RULE_02 RULE_21

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic [7:0] idx;
    logic       hit;
    logic [7:0] wb;

    assign acc = apb_req.psel && apb_req.penable;
    assign wr  = acc && apb_req.pwrite;
    assign idx = apb_req.paddr[9:2];
    assign wb  = apb_req.pwdata[7:0];
    assign hit = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[31:10] == '0) &&
                 (idx inside {`PIC_IDX_EN_A, `PIC_IDX_EN_B, `PIC_IDX_PMSB_A, `PIC_IDX_PLSB_A,
                              `PIC_IDX_PMSB_B, `PIC_IDX_PLSB_B, `PIC_IDX_TCTRL,
                              `PIC_IDX_PEND, `PIC_IDX_CORE, `PIC_IDX_STAT});

    logic [7:0] tctrl;
    assign tctrl = {4'h0, st_r.ext_flag[1], st_r.trig[1], st_r.ext_flag[0], st_r.trig[0]};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [1:0] fall;
    logic       vec_go;

    assign fall   = st_r.prev_pin & ~smp[1:0];
    assign vec_go = take && core_rsp.ack;                              // RULE_19

    always_comb begin
        st_nxt          = st_r;
        st_nxt.ready    = 1'b0;
        st_nxt.err      = 1'b0;
        st_nxt.rdata    = '0;
        st_nxt.wake     = |pin_lvl;                                    // RULE_10
        if (tick) st_nxt.prev_pin = smp[1:0];

        // Software writes first so that hardware sets win;
        // a write lands only on the edge that sees pready high
        if (wr && st_r.ready && hit) begin
            case (idx)
                `PIC_IDX_EN_A:   st_nxt.en_a   = wb;
                `PIC_IDX_EN_B:   st_nxt.en_b   = wb & `PIC_EN_B_MASK;  // RULE_17
                `PIC_IDX_PMSB_A: st_nxt.pmsb_a = wb & `PIC_EN_A_MASK;
                `PIC_IDX_PLSB_A: st_nxt.plsb_a = wb & `PIC_EN_A_MASK;
                `PIC_IDX_PMSB_B: st_nxt.pmsb_b = wb & `PIC_EN_B_MASK;
                `PIC_IDX_PLSB_B: st_nxt.plsb_b = wb & `PIC_EN_B_MASK;
                `PIC_IDX_TCTRL: begin
                    st_nxt.trig     = {wb[`PIC_TC_TRIG1], wb[`PIC_TC_TRIG0]};
                    st_nxt.ext_flag = {wb[`PIC_TC_FLAG1], wb[`PIC_TC_FLAG0]};
                end
                default: ;
            endcase
        end

        // Hardware clear on vectoring
        if (vec_go) begin
            if (win == `PIC_SRC_TMR0) st_nxt.tmr_flag[0] = 1'b0;       // RULE_06
            if (win == `PIC_SRC_TMR1) st_nxt.tmr_flag[1] = 1'b0;       // RULE_06
            if (win == `PIC_SRC_PIN0 && st_r.trig[0]) st_nxt.ext_flag[0] = 1'b0; // RULE_06
            if (win == `PIC_SRC_PIN1 && st_r.trig[1]) st_nxt.ext_flag[1] = 1'b0; // RULE_06
            st_nxt.in_svc[win_lvl] = 1'b1;
        end

        // Return clears the highest level in service
        if (core_rsp.return_from_service && svc_any) st_nxt.in_svc[svc_top] = 1'b0;  // RULE_20

        // Event sets, winning over any clear
        for (int n = 0; n < 2; n++) begin
            if (st_r.trig[n] ? (tick && fall[n]) : pin_lvl[n])         // RULE_07
                st_nxt.ext_flag[n] = 1'b1;                             // RULE_08
        end
        if (timer_zero_event) st_nxt.tmr_flag[0] = 1'b1;
        if (timer_one_event)  st_nxt.tmr_flag[1] = 1'b1;

        if (acc && !st_r.ready) begin
            st_nxt.ready = 1'b1;
            st_nxt.err   = !hit;
            if (!apb_req.pwrite && hit) begin
                case (idx)
                    `PIC_IDX_EN_A:   st_nxt.rdata[7:0] = st_r.en_a;
                    `PIC_IDX_EN_B:   st_nxt.rdata[7:0] = st_r.en_b & `PIC_EN_B_MASK; // RULE_17
                    `PIC_IDX_PMSB_A: st_nxt.rdata[7:0] = st_r.pmsb_a;
                    `PIC_IDX_PLSB_A: st_nxt.rdata[7:0] = st_r.plsb_a;
                    `PIC_IDX_PMSB_B: st_nxt.rdata[7:0] = st_r.pmsb_b;
                    `PIC_IDX_PLSB_B: st_nxt.rdata[7:0] = st_r.plsb_b;
                    `PIC_IDX_TCTRL:  st_nxt.rdata[7:0] = tctrl;
                    `PIC_IDX_PEND:   st_nxt.rdata[14:0] = pend;
                    `PIC_IDX_CORE:   st_nxt.rdata[7:0] = {2'b00, take, found, win};
                    `PIC_IDX_STAT:   st_nxt.rdata[7:0] = {2'b00, win_lvl, st_r.in_svc};
                    default:         st_nxt.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign apb_rsp.prdata  = st_r.rdata;
    assign apb_rsp.pready  = st_r.ready;
    assign apb_rsp.pslverr = st_r.err;

    assign core_req.irq_req = take;
    assign core_req.vector  = `PIC_VEC_BASE + (16'(win) << `PIC_VEC_SHIFT); // RULE_05
    assign core_req.src_num = win;
    assign core_req.level   = win_lvl;
    assign wake_request     = st_r.wake;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    gate_blocks_all_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.en_a[`PIC_GATE_BIT] |-> !core_req.irq_req) else $error("irq with gate off"); // RULE_14
    strict_preempt_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_req.irq_req && svc_any |-> core_req.level > svc_top)
        else $error("preempt without higher level"); // RULE_02
    vector_formula_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_req.irq_req |-> core_req.vector == 16'h0003 + 16'(core_req.src_num) * 16'h0008)
        else $error("vector address wrong"); // RULE_05
    timer_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        vec_go && win == 4'h1 && !timer_zero_event |=> !st_r.tmr_flag[0])
        else $error("timer flag not cleared"); // RULE_06
    level_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
        vec_go && win == 4'h0 && !st_r.trig[0] |=> st_r.ext_flag[0])
        else $error("level flag cleared by hardware"); // RULE_06
    edge_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && st_r.trig[1] && fall[1] |=> st_r.ext_flag[1])
        else $error("edge did not set flag"); // RULE_08
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |-> st_r.en_b[7] == 1'b0 && st_r.en_b[5] == 1'b0)
        else $error("reserved enable bit set"); // RULE_17
    return_from_service_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_rsp.return_from_service && svc_any && !vec_go |=> !st_r.in_svc[$past(svc_top)])
        else $error("return did not clear level"); // RULE_20
    disabled_pending_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_req.irq_req |-> enab[core_req.src_num] && pend[core_req.src_num])
        else $error("disabled source vectored"); // RULE_22
    wake_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_lvl[0] |=> wake_request) else $error("no wake on low pin"); // RULE_10
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pready |=> !apb_rsp.pready) else $error("pready longer than one cycle");
    one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready not after one wait state");
    edge_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        vec_go && win == 4'h2 && st_r.trig[1] && !(tick && fall[1]) && !wr
        |=> !st_r.ext_flag[1])
        else $error("edge flag not cleared");
    level_sets_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        !st_r.trig[0] && pin_lvl[0] |=> st_r.ext_flag[0])
        else $error("level did not set flag");
    timer_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
        timer_one_event |=> st_r.tmr_flag[1]) else $error("timer event not latched");

    vector_taken_c: cover property (@(posedge pclk) disable iff (!presetn) vec_go);
    nested_c: cover property (@(posedge pclk) disable iff (!presetn) vec_go && svc_any);
    edge_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        tick && st_r.trig[0] && fall[0]);
    return_from_service_c: cover property (@(posedge pclk) disable iff (!presetn) core_rsp.return_from_service && svc_any);
    masked_pending_c: cover property (@(posedge pclk) disable iff (!presetn) |(pend & ~emap));
endmodule

// [tb/pic_core_model.sv]
`timescale 1ns/1ps

module pic_core_model (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // Controller side
    input  wire pic_pkg::pic_core_req_type core_req,
    output pic_pkg::pic_core_rsp_type      core_rsp,
    // Bench control and observation
    input  wire logic [3:0]                ack_delay,
    input  wire logic                      return_from_service_cmd,
    output logic                           taken_stb,
    output logic [15:0]                    taken_vec,
    output logic [1:0]                     taken_lvl
);
    import pic_pkg::*;

    logic [3:0] wait_r;
    logic       take;

    assign take = core_req.irq_req && core_rsp.ack;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rsp  <= '0;
            wait_r    <= '0;
            taken_stb <= 1'b0;
            taken_vec <= '0;
            taken_lvl <= '0;
        end else begin
            core_rsp.ack  <= 1'b0;
            core_rsp.return_from_service <= return_from_service_cmd;
            taken_stb     <= take;
            if (take) begin
                taken_vec <= core_req.vector;
                taken_lvl <= core_req.level;
            end
            // Current instruction runs ack_delay + 1 cycles before the switch
            if (!core_req.irq_req || core_rsp.ack) begin
                wait_r <= '0;
            end else if (wait_r == ack_delay) begin
                core_rsp.ack <= 1'b1;
                wait_r       <= '0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// [tb/pic_tb_top.sv]
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_tb_top;
    import pic_pkg::*;

    logic             pclk;
    logic             presetn;
    pic_apb_req_type  apb_req;
    pic_apb_rsp_type  apb_rsp;
    logic             pin0_n;
    logic             pin1_n;
    logic             tmr0_ev;
    logic             tmr1_ev;
    logic [10:0]      pflags;
    pic_core_rsp_type core_rsp;
    pic_core_req_type core_req;
    logic             wake;
    logic [3:0]       ack_delay;
    logic             return_from_service_cmd;
    logic             taken_stb;
    logic [15:0]      taken_vec;
    logic [1:0]       taken_lvl;
    int               n_errors;
    int               samples_checked;
    int               cycles;

    pic_top u_dut (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .outside_request_pin_zero_n(pin0_n), .outside_request_pin_one_n(pin1_n),
        .keypad_wake_input(1'b1), .timer_zero_event(tmr0_ev), .timer_one_event(tmr1_ev),
        .periph_flags(pflags), .core_rsp(core_rsp), .core_req(core_req),
        .wake_request(wake)
    );

    pic_core_model u_core (
        .pclk(pclk), .presetn(presetn), .core_req(core_req), .core_rsp(core_rsp),
        .ack_delay(ack_delay), .return_from_service_cmd(return_from_service_cmd), .taken_stb(taken_stb),
        .taken_vec(taken_vec), .taken_lvl(taken_lvl)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        apb_req <= '{paddr: {22'h0, idx, 2'b00}, psel: 1'b1, penable: 1'b0,
                     pwrite: wr, pwdata: {24'h0, wd}};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(idx, 1'b1, d, rd, err);
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(idx, 1'b0, 8'h00, rd, err);
        chk(what, exp, rd);
    endtask

    task automatic expect_take(input logic [15:0] vec, input logic [1:0] lvl);
        int n;
        n = 0;
        forever begin
            @(posedge pclk);
            n++;
            if (taken_stb === 1'b1 || n > 60) break;
        end
        chk("taken", 1, {31'h0, taken_stb});
        chk("vector", {16'h0, vec}, {16'h0, taken_vec});
        chk("level", {30'h0, lvl}, {30'h0, taken_lvl});
    endtask

    task automatic expect_none(input int n);
        repeat (n) begin
            @(posedge pclk);
            if (taken_stb !== 1'b0) chk("no take", 0, {31'h0, taken_stb});
        end
    endtask

    task automatic do_return_from_service();
        repeat (2) @(posedge pclk);
        return_from_service_cmd <= 1'b1;
        @(posedge pclk);
        return_from_service_cmd <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic pulse_tmr(input logic which);
        if (which) tmr1_ev <= 1'b1;
        else tmr0_ev <= 1'b1;
        @(posedge pclk);
        tmr0_ev <= 1'b0;
        tmr1_ev <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] rd;
        logic        err;
        rdchk("en_a reset", `PIC_IDX_EN_A, 32'h0);
        rdchk("en_b reset", `PIC_IDX_EN_B, 32'h0);
        wr(`PIC_IDX_EN_B, 8'h5f);
        rdchk("en_b rw", `PIC_IDX_EN_B, 32'h5f);
        wr(`PIC_IDX_EN_A, 8'hff);
        rdchk("en_a rw", `PIC_IDX_EN_A, 32'hff);
        wr(`PIC_IDX_PMSB_A, 8'h7f);
        rdchk("pmsb_a", `PIC_IDX_PMSB_A, 32'h7f);
        apb(8'h10, 1'b0, 8'h00, rd, err);
        chk("unmapped err", 1, {31'h0, err});
        wr(`PIC_IDX_PMSB_A, 8'h00);
        wr(`PIC_IDX_EN_B, 8'h00);
        wr(`PIC_IDX_EN_A, 8'h10);
    endtask

    task automatic t_gate();
        pflags[0] <= 1'b1;
        expect_none(20);
        rdchk("pending", `PIC_IDX_PEND, 32'h10);
        wr(`PIC_IDX_EN_A, 8'h90);
        expect_take(16'h0023, 2'd0);
        pflags[0] <= 1'b0;
        do_return_from_service();
    endtask

    task automatic t_polling();
        int src;
        wr(`PIC_IDX_EN_A, 8'hff);
        wr(`PIC_IDX_EN_B, 8'h5f);
        pflags <= 11'h2ff;
        for (int i = 0; i < 9; i++) begin
            src = (i < 8) ? i + 4 : 13;
            expect_take(16'h0003 + 16'(8 * src), 2'd0);
            pflags[(i < 8) ? i : 9] <= 1'b0;
            do_return_from_service();
        end
        expect_none(20);
    endtask

    task automatic t_levels();
        ack_delay <= 4'd3;
        wr(`PIC_IDX_PMSB_A, 8'h38);
        wr(`PIC_IDX_PLSB_A, 8'h08);
        pflags[0] <= 1'b1;
        expect_take(16'h0023, 2'd2);
        pulse_tmr(1'b0);
        pflags[1] <= 1'b1;
        expect_none(20);
        pulse_tmr(1'b1);
        expect_take(16'h001b, 2'd3);
        do_return_from_service();
        expect_none(20);
        pflags[0] <= 1'b0;
        do_return_from_service();
        expect_take(16'h002b, 2'd2);
        pflags[1] <= 1'b0;
        do_return_from_service();
        expect_take(16'h000b, 2'd0);
        do_return_from_service();
        expect_none(20);
        ack_delay <= 4'd0;
    endtask

    task automatic t_pins();
        wr(`PIC_IDX_EN_A, 8'h80);
        wr(`PIC_IDX_TCTRL, 8'h04);
        pin0_n <= 1'b0;
        repeat (14) @(posedge pclk);
        rdchk("level flag", `PIC_IDX_TCTRL, 32'h06);
        chk("wake high", 1, {31'h0, wake});
        wr(`PIC_IDX_EN_A, 8'h81);
        expect_take(16'h0003, 2'd0);
        pin0_n <= 1'b1;
        repeat (14) @(posedge pclk);
        chk("wake low", 0, {31'h0, wake});
        wr(`PIC_IDX_TCTRL, 8'h04);
        do_return_from_service();
        wr(`PIC_IDX_EN_A, 8'h84);
        pin1_n <= 1'b0;
        expect_take(16'h0013, 2'd0);
        repeat (14) @(posedge pclk);
        pin1_n <= 1'b1;
        rdchk("edge flag clr", `PIC_IDX_TCTRL, 32'h04);
        do_return_from_service();
        expect_none(20);
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence, timeout
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        cycles = 0;
        presetn = 1'b0;
        apb_req = '0;
        pin0_n = 1'b1;
        pin1_n = 1'b1;
        tmr0_ev = 1'b0;
        tmr1_ev = 1'b0;
        pflags = '0;
        ack_delay = 4'd0;
        return_from_service_cmd = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_gate();
        t_polling();
        t_levels();
        t_pins();
        print_verdict();
    end
endmodule
